// ===== ddc_pkg.sv
// Purpose: Shared constants for the DIO and D/A control block
// Assumes: 20 MHz core clock, APB register access
// Notes: Register indices are word indices; byte address is index * 4
`default_nettype none

package ddc_pkg;

	// ==========================================================
	// Clock and D/A serial timing
	// ==========================================================
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned DAC_SCLK_HZ = 1_000_000;
	localparam int unsigned DAC_SCLK_DIV = CLK_HZ / (2 * DAC_SCLK_HZ);
	localparam int unsigned DAC_DIV_W = 8;
	localparam int unsigned DAC_WORD_W = 16;
	localparam logic [4:0] DAC_LAST_BIT = 5'h0f;

	// ==========================================================
	// Register indices
	// ==========================================================
	localparam logic [5:0] IDX_DAC_HI12 = 6'h05;
	localparam logic [5:0] IDX_DAC_LO = 6'h06;
	localparam logic [5:0] IDX_DAC_HI16 = 6'h0f;
	localparam logic [5:0] IDX_CTRL = 6'h10;
	localparam logic [5:0] IDX_PA_OUT = 6'h11;
	localparam logic [5:0] IDX_PB_OUT = 6'h12;
	localparam logic [5:0] IDX_PC_OUT = 6'h13;
	localparam logic [5:0] IDX_PA_IN = 6'h14;
	localparam logic [5:0] IDX_PB_IN = 6'h15;
	localparam logic [5:0] IDX_PC_IN = 6'h16;
	localparam logic [5:0] IDX_STATUS = 6'h17;

	// ==========================================================
	// Control register fields and reset values
	// ==========================================================
	localparam int unsigned CTRL_CNT_SEL = 7;
	localparam int unsigned CTRL_DAC_W16 = 6;
	localparam int unsigned CTRL_DAC_DEFER = 5;
	localparam int unsigned CTRL_DIR_A = 4;
	localparam int unsigned CTRL_DIR_CH = 3;
	localparam int unsigned CTRL_DIR_B = 1;
	localparam int unsigned CTRL_DIR_CL = 0;
	localparam logic [7:0] CTRL_WMASK = 8'hfb;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam logic [3:0] DAC_PAD12 = 4'h0;

	// ==========================================================
	// D/A word placement
	// ==========================================================
	function automatic logic [15:0] ddc_dac_word(
		input logic w16,
		input logic [3:0] hi12,
		input logic [7:0] hi16,
		input logic [7:0] lo
	);
		if (w16) begin
			ddc_dac_word = {hi16, lo};
		end else begin
			ddc_dac_word = {hi12, lo, DAC_PAD12};
		end
	endfunction : ddc_dac_word

endpackage : ddc_pkg

`default_nettype wire

// ===== ddc_pinmux.sv
// Purpose: Pin routing and direction for ports A, B, C and counter pins
// Assumes: Pins are split into input, output and output enable
// Notes: Purely combinational
`default_nettype none

module ddc_pinmux
	import ddc_pkg::*;
(
	input wire logic [7:0] ctrl_i,
	input wire logic [7:0] pa_out_i,
	input wire logic [7:0] pb_out_i,
	input wire logic [7:0] pc_out_i,
	input wire logic [7:0] pc_pin_i,
	input wire logic ctr_out0_i,
	output logic [7:0] pa_oe_o,
	output logic [7:0] pb_oe_o,
	output logic [7:0] pc_oe_o,
	output logic [7:0] pc_pin_o,
	output logic ctr_gate0_o,
	output logic ctr_gate1_o,
	output logic ctr_clk1_o
);

	// ==========================================================
	// Port directions
	// ==========================================================
	always_comb begin
		pa_oe_o = {8{~ctrl_i[CTRL_DIR_A]}};
		pb_oe_o = {8{~ctrl_i[CTRL_DIR_B]}};
		pc_oe_o[3:0] = {4{~ctrl_i[CTRL_DIR_CL]}};
		pc_pin_o[3:0] = pc_out_i[3:0];
		if (ctrl_i[CTRL_CNT_SEL]) begin
			pc_oe_o[7:4] = 4'h8;
			pc_pin_o[7:4] = {ctr_out0_i, 3'h0};
			ctr_gate0_o = pc_pin_i[4];
			ctr_gate1_o = pc_pin_i[5];
			ctr_clk1_o = pc_pin_i[6];
		end else begin
			pc_oe_o[7:4] = {4{~ctrl_i[CTRL_DIR_CH]}};
			pc_pin_o[7:4] = pc_out_i[7:4];
			ctr_gate0_o = 1'b0;
			ctr_gate1_o = 1'b0;
			ctr_clk1_o = 1'b0;
		end
	end

endmodule : ddc_pinmux

`default_nettype wire

// ===== ddc_dac_if.sv
// Purpose: Serial loader and update strobe for the D/A converter
// Assumes: Converter samples data on the rising serial clock
// Notes: Update requested while shifting is held until the shift ends
`default_nettype none

module ddc_dac_if
	import ddc_pkg::*;
#(
	parameter int unsigned DIV = DAC_SCLK_DIV
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic imm_i,
	input wire logic [15:0] word_i,
	input wire logic upd_i,
	output logic busy_o,
	output logic pend_o,
	output logic sclk_o,
	output logic sdi_o,
	output logic cs_n_o,
	output logic ldac_n_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_UPD
	} ddc_dac_state_t;

	typedef struct packed {
		ddc_dac_state_t st;
		logic [DAC_DIV_W-1:0] div;
		logic [15:0] sh;
		logic [4:0] cnt;
		logic sclk;
		logic pend;
		logic imm;
	} ddc_dac_st_t;

	ddc_dac_st_t s_r;
	ddc_dac_st_t s_nxt;
	logic tick;

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		s_nxt = s_r;
		tick = (s_r.div == DAC_DIV_W'(DIV - 1));
		s_nxt.div = tick ? '0 : s_r.div + 1'b1;
		if (upd_i) begin
			s_nxt.pend = 1'b1;
		end
		case (s_r.st)
			ST_IDLE: begin
				if (load_i) begin
					s_nxt.st = ST_SHIFT;
					s_nxt.sh = word_i;
					s_nxt.cnt = '0;
					s_nxt.imm = imm_i;
					s_nxt.div = '0;
				end else if (s_r.pend) begin
					s_nxt.st = ST_UPD;
					s_nxt.pend = upd_i;
					s_nxt.div = '0;
				end
			end
			ST_SHIFT: begin
				if (tick) begin
					s_nxt.sclk = ~s_r.sclk;
					if (s_r.sclk) begin
						s_nxt.sh = {s_r.sh[14:0], 1'b0};
						s_nxt.cnt = s_r.cnt + 1'b1;
						if (s_r.cnt == DAC_LAST_BIT) begin
							if (s_r.imm) begin
								s_nxt.st = ST_UPD;
							end else begin
								s_nxt.st = ST_IDLE;
							end
						end
					end
				end
			end
			ST_UPD: begin
				if (tick) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// State register
	// ==========================================================
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '{st: ST_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy_o = (s_r.st != ST_IDLE);
	assign pend_o = s_r.pend;
	assign sclk_o = s_r.sclk;
	assign sdi_o = s_r.sh[15];
	assign cs_n_o = (s_r.st != ST_SHIFT);
	assign ldac_n_o = (s_r.st != ST_UPD);

endmodule : ddc_dac_if

`default_nettype wire

// ===== ddc_top.sv
// Purpose: DIO direction, counter pin routing and D/A control over APB
// Assumes: APB slave, 32-bit data, byte address = register index * 4
// Notes: Writes to the D/A low byte stall while the converter is busy
//
// Contract
// - Counter select routes counter signals to pins
// - Digital mode: shared pins follow upper direction
// - D/A word always 16 bits, 12-bit left-justified
// - 12-bit mode: high bits from index 5
// - 16-bit mode: high bits from index 15
// - Immediate mode: low write loads then updates
// - Deferred mode: update on read of index 15
// - Port A output when direction bit zero
// - Port B output when direction bit zero
// - Upper C direction ignored under counter select
// - Lower C direction bit sets lines 3-0
//
// The placing of the registers and the APB register port were decided locally.
`default_nettype none

module ddc_top
	import ddc_pkg::*;
#(
	parameter int unsigned SCLK_DIV = DAC_SCLK_DIV
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [7:0] port_a_in_i,
	output logic [7:0] port_a_out_o,
	output logic [7:0] port_a_oe_o,
	input wire logic [7:0] port_b_in_i,
	output logic [7:0] port_b_out_o,
	output logic [7:0] port_b_oe_o,
	input wire logic [7:0] port_c_in_i,
	output logic [7:0] port_c_out_o,
	output logic [7:0] port_c_oe_o,
	input wire logic ctr_out0_i,
	output logic ctr_gate0_o,
	output logic ctr_gate1_o,
	output logic ctr_clk1_o,
	output logic dac_sclk_o,
	output logic dac_sdi_o,
	output logic dac_cs_n_o,
	output logic dac_ldac_n_o
);

	// ==========================================================
	// Register state
	// ==========================================================
	typedef struct packed {
		logic [7:0] ctrl;
		logic [3:0] dac_hi12;
		logic [7:0] dac_lo;
		logic [7:0] dac_hi16;
		logic [7:0] pa_out;
		logic [7:0] pb_out;
		logic [7:0] pc_out;
		logic dac_load;
		logic dac_imm;
		logic [15:0] dac_word;
		logic upd_req;
	} ddc_regs_t;

	ddc_regs_t r_r;
	ddc_regs_t r_nxt;

	logic [5:0] idx;
	logic mapped;
	logic writable;
	logic dac_busy;
	logic dac_pend;
	logic stall;
	logic access;
	logic wr_acc;
	logic rd_acc;
	logic [7:0] rd_byte;

	// ==========================================================
	// Address decode
	// ==========================================================
	assign idx = paddr_i[7:2];

	always_comb begin
		mapped = 1'b1;
		writable = 1'b1;
		case (idx)
			IDX_DAC_HI12,
			IDX_DAC_LO,
			IDX_DAC_HI16,
			IDX_CTRL,
			IDX_PA_OUT,
			IDX_PB_OUT,
			IDX_PC_OUT: begin
				writable = 1'b1;
			end
			IDX_PA_IN,
			IDX_PB_IN,
			IDX_PC_IN,
			IDX_STATUS: begin
				writable = 1'b0;
			end
			default: begin
				mapped = 1'b0;
				writable = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// APB handshake
	// ==========================================================
	always_comb begin
		stall = psel_i & pwrite_i & (idx == IDX_DAC_LO) &
			(dac_busy | r_r.dac_load);
		pready_o = ~stall;
		pslverr_o = psel_i & penable_i & ~mapped;
		access = psel_i & penable_i & ~stall;
		wr_acc = access & pwrite_i & writable;
		rd_acc = access & ~pwrite_i & mapped;
	end

	// ==========================================================
	// Read data
	// ==========================================================
	always_comb begin
		case (idx)
			IDX_DAC_HI12: begin
				rd_byte = {4'h0, r_r.dac_hi12};
			end
			IDX_DAC_LO: begin
				rd_byte = r_r.dac_lo;
			end
			IDX_DAC_HI16: begin
				rd_byte = r_r.dac_hi16;
			end
			IDX_CTRL: begin
				rd_byte = r_r.ctrl;
			end
			IDX_PA_OUT: begin
				rd_byte = r_r.pa_out;
			end
			IDX_PB_OUT: begin
				rd_byte = r_r.pb_out;
			end
			IDX_PC_OUT: begin
				rd_byte = r_r.pc_out;
			end
			IDX_PA_IN: begin
				rd_byte = port_a_in_i;
			end
			IDX_PB_IN: begin
				rd_byte = port_b_in_i;
			end
			IDX_PC_IN: begin
				rd_byte = port_c_in_i;
			end
			IDX_STATUS: begin
				rd_byte = {6'h00, dac_pend, dac_busy | r_r.dac_load};
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
		prdata_o = (psel_i & ~pwrite_i) ? {24'h000000, rd_byte} : 32'h0;
	end

	// ==========================================================
	// Register next state
	// ==========================================================
	always_comb begin
		r_nxt = r_r;
		r_nxt.dac_load = 1'b0;
		r_nxt.upd_req = 1'b0;
		if (wr_acc) begin
			case (idx)
				IDX_DAC_HI12: begin
					r_nxt.dac_hi12 = pwdata_i[3:0];
				end
				IDX_DAC_LO: begin
					r_nxt.dac_lo = pwdata_i[7:0];
					r_nxt.dac_load = 1'b1;
					r_nxt.dac_imm = ~r_r.ctrl[CTRL_DAC_DEFER];
					r_nxt.dac_word = ddc_dac_word(
						r_r.ctrl[CTRL_DAC_W16],
						r_r.dac_hi12,
						r_r.dac_hi16,
						pwdata_i[7:0]);
				end
				IDX_DAC_HI16: begin
					r_nxt.dac_hi16 = pwdata_i[7:0];
				end
				IDX_CTRL: begin
					r_nxt.ctrl = pwdata_i[7:0] & CTRL_WMASK;
				end
				IDX_PA_OUT: begin
					r_nxt.pa_out = pwdata_i[7:0];
				end
				IDX_PB_OUT: begin
					r_nxt.pb_out = pwdata_i[7:0];
				end
				IDX_PC_OUT: begin
					r_nxt.pc_out = pwdata_i[7:0];
				end
				default: begin
					r_nxt.ctrl = r_r.ctrl;
				end
			endcase
		end
		if (rd_acc & (idx == IDX_DAC_HI16) & r_r.ctrl[CTRL_DAC_DEFER]) begin
			r_nxt.upd_req = 1'b1;
		end
	end

	// ==========================================================
	// Register update
	// ==========================================================
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_r <= '{
				ctrl: CTRL_RST,
				dac_hi12: NIB_RST,
				dac_lo: BYTE_RST,
				dac_hi16: BYTE_RST,
				pa_out: BYTE_RST,
				pb_out: BYTE_RST,
				pc_out: BYTE_RST,
				default: '0
			};
		end else begin
			r_r <= r_nxt;
		end
	end

	// ==========================================================
	// Port outputs and pin routing
	// ==========================================================
	assign port_a_out_o = r_r.pa_out;
	assign port_b_out_o = r_r.pb_out;

	ddc_pinmux u_pinmux (
		.ctrl_i(r_r.ctrl),
		.pa_out_i(r_r.pa_out),
		.pb_out_i(r_r.pb_out),
		.pc_out_i(r_r.pc_out),
		.pc_pin_i(port_c_in_i),
		.ctr_out0_i(ctr_out0_i),
		.pa_oe_o(port_a_oe_o),
		.pb_oe_o(port_b_oe_o),
		.pc_oe_o(port_c_oe_o),
		.pc_pin_o(port_c_out_o),
		.ctr_gate0_o(ctr_gate0_o),
		.ctr_gate1_o(ctr_gate1_o),
		.ctr_clk1_o(ctr_clk1_o)
	);

	// ==========================================================
	// D/A converter interface
	// ==========================================================
	ddc_dac_if #(
		.DIV(SCLK_DIV)
	) u_dac (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(r_r.dac_load),
		.imm_i(r_r.dac_imm),
		.word_i(r_r.dac_word),
		.upd_i(r_r.upd_req),
		.busy_o(dac_busy),
		.pend_o(dac_pend),
		.sclk_o(dac_sclk_o),
		.sdi_o(dac_sdi_o),
		.cs_n_o(dac_cs_n_o),
		.ldac_n_o(dac_ldac_n_o)
	);

endmodule : ddc_top

`default_nettype wire

// ===== ddc_top_checker.sv
// Purpose: Port-level checks for ddc_top
// Assumes: One clock, async active-low reset
// Notes: Attached by bind
`default_nettype none

module ddc_top_checker
	import ddc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic [7:0] port_a_oe_o,
	input wire logic [7:0] port_b_oe_o,
	input wire logic [7:0] port_c_oe_o,
	input wire logic ctr_gate0_o,
	input wire logic ctr_gate1_o,
	input wire logic ctr_clk1_o,
	input wire logic dac_sclk_o,
	input wire logic dac_cs_n_o,
	input wire logic dac_ldac_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// ==========================================================
	// Assertions
	// ==========================================================
	rst_dir_a: assert property (
		$rose(rst_n_i) |-> (port_a_oe_o == 8'hff) && (port_b_oe_o == 8'hff)
		&& (port_c_oe_o == 8'hff)) else $error("Ports not outputs after reset");
	dir_a_a: assert property (
		port_a_oe_o inside {8'h00, 8'hff}) else $error("Port A split direction");
	dir_b_a: assert property (
		port_b_oe_o inside {8'h00, 8'hff}) else $error("Port B split direction");
	dir_cl_a: assert property (
		port_c_oe_o[3:0] inside {4'h0, 4'hf}) else $error("Lower C split");
	dir_ch_a: assert property (
		port_c_oe_o[7:4] inside {4'h0, 4'hf, 4'h8}) else $error("Upper C bad");
	cnt_pin_a: assert property (
		(ctr_gate0_o || ctr_gate1_o || ctr_clk1_o) |-> port_c_oe_o[7:4] == 4'h8)
		else $error("Counter pins not routed");
	stall_only_a: assert property (
		!pready_o |-> psel_i && pwrite_i && (paddr_i[7:2] == IDX_DAC_LO))
		else $error("Unexpected wait state");
	stall_end_a: assert property (
		$fell(pready_o) |-> ##[1:400] pready_o) else $error("Stall too long");
	frame_clk_a: assert property (
		dac_sclk_o |-> !dac_cs_n_o) else $error("Serial clock outside frame");
	upd_frame_a: assert property (
		!dac_ldac_n_o |-> dac_cs_n_o) else $error("Update during shift");
endmodule : ddc_top_checker

bind ddc_top ddc_top_checker u_chk (
	.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o),
	.port_a_oe_o(port_a_oe_o), .port_b_oe_o(port_b_oe_o),
	.port_c_oe_o(port_c_oe_o), .ctr_gate0_o(ctr_gate0_o),
	.ctr_gate1_o(ctr_gate1_o), .ctr_clk1_o(ctr_clk1_o),
	.dac_sclk_o(dac_sclk_o), .dac_cs_n_o(dac_cs_n_o),
	.dac_ldac_n_o(dac_ldac_n_o)
);

`default_nettype wire

// ===== ddc_dac_model.sv
// Purpose: Behavioural serial D/A converter
// Assumes: Data sampled on rising serial clock, MSB first
// Notes: Output register moves on falling update strobe
`default_nettype none

module ddc_dac_model (
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic cs_n_i,
	input wire logic ldac_n_i,
	output logic [15:0] word_o,
	output logic [15:0] out_o,
	output logic [4:0] bits_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sh;

	initial begin
		sh = 16'h0000;
		word_o = 16'h0000;
		out_o = 16'h0000;
		bits_o = 5'h00;
	end
	// ==========================================================
	// Shift, latch and update
	// ==========================================================
	always @(negedge cs_n_i or posedge sclk_i) begin
		if (sclk_i && !cs_n_i) begin
			sh <= {sh[14:0], sdi_i};
			bits_o <= bits_o + 5'h01;
		end else if (!sclk_i) begin
			bits_o <= 5'h00;
		end
	end
	always @(posedge cs_n_i) begin
		word_o <= sh;
	end
	always @(negedge ldac_n_i) begin
		out_o <= sh;
	end
endmodule : ddc_dac_model

`default_nettype wire

// ===== testbench.sv
// Purpose: Directed APB test of ddc_top
// Assumes: Short serial divider for run time
// Notes: Far-side converter is a behavioural model
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
	$display("BAD %0t got %h exp %h", $time, (a), (b)); end end

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ddc_pkg::*;
	logic core_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0;
	logic pwrite_i = 0, ctr_out0_i = 0, pready_o, pslverr_o, se;
	logic [7:0] paddr_i = 8'h00, port_a_in_i = 8'hc3, port_b_in_i = 8'h00;
	logic [7:0] port_c_in_i = 8'h00, port_a_out_o, port_b_out_o;
	logic [7:0] port_c_out_o, port_a_oe_o, port_b_oe_o, port_c_oe_o;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	logic ctr_gate0_o, ctr_gate1_o, ctr_clk1_o, dac_sclk_o, dac_sdi_o;
	logic dac_cs_n_o, dac_ldac_n_o, rdy;
	logic [15:0] dw, dout;
	logic [4:0] bits;
	int err_count = 0, checked = 0, n;
	logic [7:0] ctab [6] = '{8'h10, 8'h02, 8'h01, 8'h08, 8'h80, 8'h8c};
	logic [23:0] otab [6] = '{24'h00ffff, 24'hff00ff, 24'hfffff0,
		24'hffff0f, 24'hffff8f, 24'hffff8f};

	ddc_top #(.SCLK_DIV(2)) DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.port_a_in_i(port_a_in_i), .port_a_out_o(port_a_out_o),
		.port_a_oe_o(port_a_oe_o), .port_b_in_i(port_b_in_i),
		.port_b_out_o(port_b_out_o), .port_b_oe_o(port_b_oe_o),
		.port_c_in_i(port_c_in_i), .port_c_out_o(port_c_out_o),
		.port_c_oe_o(port_c_oe_o), .ctr_out0_i(ctr_out0_i),
		.ctr_gate0_o(ctr_gate0_o), .ctr_gate1_o(ctr_gate1_o),
		.ctr_clk1_o(ctr_clk1_o), .dac_sclk_o(dac_sclk_o),
		.dac_sdi_o(dac_sdi_o), .dac_cs_n_o(dac_cs_n_o),
		.dac_ldac_n_o(dac_ldac_n_o));
	ddc_dac_model u_dac (.sclk_i(dac_sclk_o), .sdi_i(dac_sdi_o),
		.cs_n_i(dac_cs_n_o), .ldac_n_i(dac_ldac_n_o), .word_o(dw),
		.out_o(dout), .bits_o(bits));

	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end
	// ==========================================================
	// Tasks
	// ==========================================================
	task report_and_stop;
		if (err_count == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		for (n = 0; n < 600; n++) begin
			@(negedge core_clk_i);
			rdy = pready_o;
			rd = prdata_o;
			se = pslverr_o;
			@(posedge core_clk_i);
			if (rdy === 1'b1) break;
		end
		if (n == 600) begin
			err_count++;
			report_and_stop();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(negedge core_clk_i);
	endtask : apb
	task wait_idle;
		for (int k = 0; k < 100; k++) begin
			apb(1'b0, 8'h5c, 32'h0);
			if (rd[1:0] === 2'b00) return;
		end
		err_count++;
		report_and_stop();
	endtask : wait_idle
	// ==========================================================
	// Sequence
	// ==========================================================
	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		apb(1'b0, 8'h40, 32'h0);
		`CHK(rd, 32'h0)
		`CHK({port_a_oe_o, port_b_oe_o, port_c_oe_o}, 24'hffffff)
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, 8'h40, {24'h0, ctab[i]});
			`CHK({port_a_oe_o, port_b_oe_o, port_c_oe_o}, otab[i])
		end
		apb(1'b0, 8'h40, 32'h0);
		`CHK(rd, 32'h88)
		@(posedge core_clk_i);
		port_c_in_i <= 8'h50;
		ctr_out0_i <= 1'b1;
		@(negedge core_clk_i);
		`CHK({ctr_clk1_o, ctr_gate1_o, ctr_gate0_o, port_c_out_o[7]}, 4'hb)
		apb(1'b1, 8'h40, 32'h0);
		`CHK({ctr_clk1_o, ctr_gate1_o, ctr_gate0_o}, 3'h0)
		apb(1'b0, 8'hfc, 32'h0);
		`CHK({se, rd}, 33'h100000000)
		apb(1'b1, 8'h44, 32'h5a);
		`CHK(port_a_out_o, 8'h5a)
		apb(1'b0, 8'h50, 32'h0);
		`CHK(rd, 32'hc3)
		apb(1'b1, 8'h14, 32'ha5);
		apb(1'b1, 8'h18, 32'h3c);
		apb(1'b1, 8'h18, 32'hc3);
		wait_idle();
		`CHK({dout, bits}, {16'h5c30, 5'h10})
		apb(1'b1, 8'h40, 32'h60);
		apb(1'b1, 8'h3c, 32'h9e);
		apb(1'b1, 8'h18, 32'h71);
		wait_idle();
		`CHK({dw, dout}, 32'h9e715c30)
		apb(1'b0, 8'h3c, 32'h0);
		for (n = 0; n < 400 && dac_ldac_n_o !== 1'b0; n++) begin
			@(posedge core_clk_i);
		end
		if (n == 400) begin
			err_count++;
		end
		@(negedge core_clk_i);
		`CHK(dout, 16'h9e71)
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
